// >>> include/tsq_defs.svh
`ifndef TSQ_DEFS_SVH
`define TSQ_DEFS_SVH

// Command byte layout, start bit first on the wire
`define TSQ_CMD_BITS 8
`define TSQ_CMD_START_POS 7
`define TSQ_CMD_CH_MSB_POS 6
`define TSQ_CMD_CH_LSB_POS 4
`define TSQ_CMD_MODE8_POS 3
`define TSQ_CMD_SE_POS 2
`define TSQ_CMD_PD_HI_POS 1
`define TSQ_CMD_PD_LO_POS 0

// Sequencing counts in shift clock falling edges after the start bit
`define TSQ_ACQ_START_FALL 5
`define TSQ_ACQ_CYCLES 3
`define TSQ_RES_BITS 12
`define TSQ_RES_BITS8 8
`define TSQ_FULL_SCALE 4096

// Channel codes
`define TSQ_CH_XPOS 3'h1
`define TSQ_CH_AUXA 3'h2
`define TSQ_CH_YPOS 3'h5
`define TSQ_CH_AUXB 3'h6

`endif

// >>> include/tsq_pkg.sv
package tsq_pkg;

  typedef enum logic [1:0] {
    TSQ_IDLE,
    TSQ_CMD,
    TSQ_ACQ,
    TSQ_CONV
  } tsq_state_e;

  // Decoded command fields
  typedef struct packed {
    logic [2:0] channel;
    logic mode_8bit;
    logic single_ended_select;
    logic power_down_sel_hi;
    logic power_down_sel_lo;
  } tsq_cmd_s;

  // Panel driver and mux settings
  typedef struct packed {
    logic x_drivers_on;
    logic y_drivers_on;
    logic [1:0] mux_sel;
    logic valid;
  } tsq_route_s;

endpackage

// >>> rtl/tsq_edge_sync.sv
`include "tsq_defs.svh"

// Two-stage synchroniser for serial pins plus clock edge finder
module tsq_edge_sync
  import tsq_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Raw pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  // Synchronised levels and edges
  output logic cs_n_s,
  output logic din_s,
  output logic sclk_rise,
  output logic sclk_fall
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sclk_prev_q;

  // First stage feeds only the second stage; reset to idle pin levels (select high, clock low)
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 3'h2; // [RQ2]
      sync_q <= 3'h2; // [RQ2]
      sclk_prev_q <= 1'h0;
    end else begin
      meta_q <= {din_pin, cs_n_pin, sclk_pin};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[0];
    end
  end

  assign cs_n_s = sync_q[1];
  assign din_s = sync_q[2];
  assign sclk_rise = sync_q[0] & ~sclk_prev_q;
  assign sclk_fall = ~sync_q[0] & sclk_prev_q;

endmodule

// >>> rtl/tsq_touch_adc_serial_sequencer.sv
`include "tsq_defs.svh"

// Functional notes
// RQ1: Each result bit changes on the shift clock falling edge.
// RQ2: Result output released to high impedance whenever chip select is high.
// RQ3: Busy output released to high impedance whenever chip select is high.
// RQ4: Command bits sampled on the shift clock rising edge.
// RQ5: Chip select low enables shifting; serial activity ignored while it is high.
// RQ6: Shift clock also paces conversion; host keeps it toggling.
// RQ7: Acquisition starts on fifth falling edge after start bit.
// RQ8: Acquisition lasts exactly three shift clock cycles, then the sample holds.
// RQ9: Touch interrupt is open drain, only pulls low.
// RQ10: Result sent MSB first, then remaining bits, then trailing zeros.
// RQ11: Result is straight binary, full scale 4096 codes.
// RQ12: Channel and single-ended bits choose input and panel drivers; others invalid.
// RQ13: Both power-down bits set keep the panel drivers on between conversions.
// RQ14: Busy high from end of acquisition until the first result bit.
module tsq_touch_adc_serial_sequencer
  import tsq_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic shift_and_conversion_clock,
  input wire logic chip_select_n,
  input wire logic serial_cmd_in,
  output logic result_out,
  output logic result_out_en_n,
  output logic busy_out,
  output logic busy_out_en_n,
  // Open-drain touch interrupt
  input wire logic pen_touched,
  output logic touch_detect_irq_o,
  output logic touch_detect_irq_en_n,
  // Converter core
  input wire logic [11:0] sample_code,
  output logic track_en,
  output logic hold_strobe,
  // Panel and mux control
  output logic x_drivers_on,
  output logic y_drivers_on,
  output logic [1:0] mux_sel,
  output logic single_ended_select,
  output logic cmd_invalid
);

  logic cs_n_s;
  logic din_s;
  logic sclk_rise;
  logic sclk_fall;
  tsq_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] fall_cnt_q;
  logic [6:0] cmd_sr_q;
  tsq_cmd_s cmd_q;
  tsq_route_s route_q;
  logic [11:0] res_sr_q;
  logic [3:0] res_cnt_q;
  logic result_q;
  logic busy_q;
  logic track_q;
  logic hold_q;

  tsq_edge_sync u_sync (
    .clk(clk),
    .rst(rst),
    .sclk_pin(shift_and_conversion_clock),
    .cs_n_pin(chip_select_n),
    .din_pin(serial_cmd_in),
    .cs_n_s(cs_n_s),
    .din_s(din_s),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall)
  );

  // Channel decode into drivers and mux
  function automatic tsq_route_s decode_route(input tsq_cmd_s c);
    tsq_route_s r;
    r = '0;
    r.valid = 1'h1;
    case (c.channel)
      `TSQ_CH_XPOS: r.y_drivers_on = 1'h1; // [RQ12]
      `TSQ_CH_YPOS: begin
        r.x_drivers_on = 1'h1; // [RQ12]
        r.mux_sel = 2'h1;
      end
      `TSQ_CH_AUXA: begin
        r.mux_sel = 2'h2;
        r.valid = c.single_ended_select;
      end
      `TSQ_CH_AUXB: begin
        r.mux_sel = 2'h3;
        r.valid = c.single_ended_select;
      end
      default: r.valid = 1'h0; // [RQ12]
    endcase
    return r;
  endfunction

  // Command capture and sequencing on shift clock edges
  always_ff @(posedge clk) begin
    if (rst || cs_n_s) begin // [RQ5]
      state_q <= TSQ_IDLE;
      bit_cnt_q <= 3'h0;
      fall_cnt_q <= 4'h0;
      cmd_sr_q <= 7'h00;
    end else begin
      case (state_q)
        TSQ_IDLE: begin
          if (sclk_rise && din_s) begin // [RQ4]
            state_q <= TSQ_CMD;
            bit_cnt_q <= 3'h0;
            fall_cnt_q <= 4'h0;
          end
        end
        TSQ_CMD: begin
          if (sclk_rise && bit_cnt_q != 3'h7) begin
            cmd_sr_q <= {cmd_sr_q[5:0], din_s}; // [RQ4]
            bit_cnt_q <= bit_cnt_q + 3'h1;
          end
          if (sclk_fall) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
            if (fall_cnt_q == 4'(`TSQ_ACQ_START_FALL - 1)) begin
              state_q <= TSQ_ACQ; // [RQ7]
              fall_cnt_q <= 4'h0;
            end
          end
        end
        TSQ_ACQ: begin
          // Last command bits still arrive while the input is tracked
          if (sclk_rise && bit_cnt_q != 3'h7) begin
            cmd_sr_q <= {cmd_sr_q[5:0], din_s}; // [RQ4]
            bit_cnt_q <= bit_cnt_q + 3'h1;
          end
          if (sclk_fall) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
            if (fall_cnt_q == 4'(`TSQ_ACQ_CYCLES - 1)) begin
              state_q <= TSQ_CONV; // [RQ8]
              fall_cnt_q <= 4'h0;
            end
          end
        end
        TSQ_CONV: begin
          if (sclk_fall) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
            if (fall_cnt_q == 4'hF) begin
              state_q <= TSQ_IDLE; // [RQ6]
            end
          end
        end
        default: state_q <= TSQ_IDLE;
      endcase
    end
  end

  // Latch command fields once the full byte is in
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= '0;
      route_q <= '0;
    end else if (state_q == TSQ_ACQ && fall_cnt_q == 4'(`TSQ_ACQ_CYCLES - 1) && sclk_fall) begin
      cmd_q <= cmd_sr_q;
      route_q <= decode_route(cmd_sr_q);
    end
  end

  // Acquisition window and hold pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      track_q <= 1'h0;
      hold_q <= 1'h0;
    end else begin
      track_q <= (state_q == TSQ_ACQ) && !cs_n_s; // [RQ8]
      hold_q <= (state_q == TSQ_ACQ) && sclk_fall && fall_cnt_q == 4'(`TSQ_ACQ_CYCLES - 1);
    end
  end

  // Result shifter: MSB first, zeros after the last bit
  always_ff @(posedge clk) begin
    if (rst || cs_n_s) begin
      res_sr_q <= 12'h000;
      res_cnt_q <= 4'h0;
      result_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      if (hold_q) begin
        res_sr_q <= sample_code; // [RQ11]
        res_cnt_q <= 4'h0;
        busy_q <= 1'h1; // [RQ14]
      end else if (state_q == TSQ_CONV && sclk_fall) begin
        busy_q <= 1'h0; // [RQ14]
        if (res_cnt_q < 4'(cmd_q.mode_8bit ? `TSQ_RES_BITS8 : `TSQ_RES_BITS)) begin
          result_q <= res_sr_q[11]; // [RQ1] [RQ10]
          res_sr_q <= {res_sr_q[10:0], 1'h0};
          res_cnt_q <= res_cnt_q + 4'h1;
        end else begin
          result_q <= 1'h0; // [RQ10]
        end
      end
    end
  end

  // Pin drivers; enables are active low
  assign result_out = result_q;
  assign result_out_en_n = cs_n_s; // [RQ2]
  assign busy_out = busy_q;
  assign busy_out_en_n = cs_n_s; // [RQ3]
  assign touch_detect_irq_o = 1'h0; // [RQ9]
  assign touch_detect_irq_en_n = ~(pen_touched && state_q == TSQ_IDLE); // [RQ9]
  assign track_en = track_q;
  assign hold_strobe = hold_q;
  assign single_ended_select = cmd_q.single_ended_select;
  assign cmd_invalid = ~route_q.valid;
  assign mux_sel = route_q.mux_sel;
  // Drivers stay on between conversions when both power-down bits are set
  assign x_drivers_on = route_q.x_drivers_on &&
    ((state_q != TSQ_IDLE) || (cmd_q.power_down_sel_hi && cmd_q.power_down_sel_lo)); // [RQ13]
  assign y_drivers_on = route_q.y_drivers_on &&
    ((state_q != TSQ_IDLE) || (cmd_q.power_down_sel_hi && cmd_q.power_down_sel_lo)); // [RQ13]

  // Checks
  acq_len_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    $rose(track_q) |-> track_q throughout (##[1:60] hold_q)) else $error("acquisition window broken");
  hold_end_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    hold_q |=> !track_q) else $error("track stayed on after hold");
  dout_hiz_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    cs_n_s |-> result_out_en_n) else $error("result driven with cs high");
  busy_hiz_a: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    cs_n_s |-> busy_out_en_n) else $error("busy driven with cs high");
  busy_set_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
    hold_q && !cs_n_s |=> busy_q) else $error("busy not raised at hold");
  dout_fall_a: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    !cs_n_s && $past(!cs_n_s) && result_q != $past(result_q) |-> $past(sclk_fall)) else $error("data moved off edge");
  irq_od_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    !touch_detect_irq_en_n |-> !touch_detect_irq_o) else $error("irq drove high");
  ignore_cs_a: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    cs_n_s |=> state_q == TSQ_IDLE) else $error("sequencer ran with cs high");

endmodule

// >>> sim/tsq_host_model.sv
// Host side of the serial port: frames commands, collects result bits
module tsq_host_model (
  // System
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic result_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int falls;
  logic [23:0] cap;

  // Shift clock stands low and chip select high between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    falls = 0;
  end

  // One frame of n clocks, half period h; sel low keeps chip select high
  task automatic frame(input logic [7:0] cmd, input int n, input int h, input logic sel);
    falls = 0;
    @(posedge clk);
    cs_n <= ~sel;
    repeat (h) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      din <= (i < 8) ? cmd[7 - i] : i[0];
      repeat (h) @(posedge clk);
      sclk <= 1'b1;
      repeat (h) @(posedge clk);
      sclk <= 1'b0;
      cap <= {cap[22:0], result_out};
      falls <= falls + 1;
    end
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// >>> sim/tb_top.sv
// Bench for the touch converter serial sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pen_touched = 1'b0;
  logic [11:0] sample_code = 12'h000;
  logic sclk, cs_n, din, result_out, result_out_en_n, busy_out, busy_out_en_n;
  logic touch_detect_irq_o, touch_detect_irq_en_n, track_en, hold_strobe;
  logic x_drivers_on, y_drivers_on, single_ended_select, cmd_invalid;
  logic [1:0] mux_sel, snap_m, snap_en, end_drv;
  logic [3:0] snap;
  logic [2:0] cs_hist = 3'b000;
  logic trk_q, bsy_q, cs_q, dout_pin;
  int falls, trk_at, hold_at, bsy_up, bsy_dn, trk_n = 0, bad_count = 0, compares = 0;

  always #25 clk = ~clk;

  tsq_touch_adc_serial_sequencer i_tsq_touch_adc_serial_sequencer (
    .clk, .rst, .shift_and_conversion_clock(sclk), .chip_select_n(cs_n), .serial_cmd_in(din),
    .result_out, .result_out_en_n, .busy_out, .busy_out_en_n, .pen_touched, .touch_detect_irq_o,
    .touch_detect_irq_en_n, .sample_code, .track_en, .hold_strobe, .x_drivers_on, .y_drivers_on,
    .mux_sel, .single_ended_select, .cmd_invalid
  );
  // A released result line shows the opposite level to the host
  assign dout_pin = result_out_en_n ? ~result_out : result_out;
  tsq_host_model i_tsq_host_model (.clk, .sclk, .cs_n, .din, .result_out(dout_pin));

  always_comb falls = i_tsq_host_model.falls;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Marks the host falling-edge count at which each event shows
  always @(posedge clk) begin
    cs_hist <= {cs_hist[1:0], cs_n};
    trk_q <= track_en;
    bsy_q <= busy_out;
    cs_q <= cs_n;
    if (cs_q && !cs_n) begin
      trk_at <= 99;
      hold_at <= 99;
      bsy_up <= 99;
      bsy_dn <= 99;
    end
    if (track_en && !trk_q) begin
      trk_at <= falls;
      trk_n <= trk_n + 1;
    end
    if (hold_strobe) hold_at <= falls;
    if (falls == 8) begin
      snap <= {x_drivers_on, y_drivers_on, cmd_invalid, single_ended_select};
      snap_m <= mux_sel;
      snap_en <= {result_out_en_n, busy_out_en_n};
    end
    if (busy_out && !bsy_q) bsy_up <= falls;
    if (!busy_out && bsy_q) bsy_dn <= falls;
    if (!cs_q && cs_n) end_drv <= {x_drivers_on, y_drivers_on};
    if (cs_hist == 3'b111) check("hiz", 32'({result_out_en_n, busy_out_en_n}), 32'h3);
  end

  // One 24-clock conversion; e holds x drivers, y drivers, invalid
  task automatic t_conv(input logic [7:0] c, input logic [11:0] code, input logic [2:0] e,
                        input logic [1:0] m, input int h);
    sample_code <= code;
    i_tsq_host_model.frame(c, 24, h, 1'b1);
    check("drv", 32'(snap), 32'({e, c[2]}));
    check("end_drv", 32'(end_drv), (c[1:0] == 2'b11) ? 32'(e[2:1]) : 32'h0);
    if (!e[0]) begin
      check("mux", 32'(snap_m), 32'(m));
      check("en", 32'(snap_en), 32'h0);
      check("trk_at", trk_at, 5);
      check("hold_at", hold_at, 8);
      check("bsy_up", bsy_up, 8);
      check("bsy_dn", bsy_dn, 9);
      check("res", 32'(i_tsq_host_model.cap[14:0]),
            c[3] ? 32'({code[11:4], 7'h00}) : 32'({code, 3'h0}));
    end
  endtask

  // Every listed channel single-ended, X and Y also differential, plus one unlisted code
  task automatic t_channels;
    t_conv(8'h94, 12'hA5C, 3'b010, 2'd0, 4);
    t_conv(8'hA4, 12'h001, 3'b000, 2'd2, 4);
    t_conv(8'hD4, 12'hFFF, 3'b100, 2'd1, 4);
    t_conv(8'hE4, 12'h800, 3'b000, 2'd3, 4);
    t_conv(8'h90, 12'h3C7, 3'b010, 2'd0, 4);
    t_conv(8'hD0, 12'h7FE, 3'b100, 2'd1, 4);
    t_conv(8'h84, 12'h555, 3'b001, 2'd0, 4);
  endtask

  // Short result and drivers kept on, host clocking slowly first
  task automatic t_mode8_hold;
    t_conv(8'h9F, 12'hB6D, 3'b010, 2'd0, 8);
    t_conv(8'hD3, 12'h2A4, 3'b100, 2'd1, 4);
  endtask

  // Chip select dropped mid-conversion, then a clean frame
  task automatic t_abort;
    i_tsq_host_model.frame(8'hD4, 12, 4, 1'b1);
    t_conv(8'hE4, 12'h0F0, 3'b000, 2'd3, 4);
  endtask

  // Traffic with chip select high starts nothing
  task automatic t_cs_ignore;
    int n;
    n = trk_n;
    i_tsq_host_model.frame(8'h94, 24, 4, 1'b0);
    check("ignored", trk_n, n);
  endtask

  // Touch only pulls the interrupt line low
  task automatic t_pen;
    pen_touched <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("pen_on", 32'({touch_detect_irq_o, touch_detect_irq_en_n}), 32'h0);
    @(posedge clk);
    pen_touched <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("pen_off", 32'({touch_detect_irq_o, touch_detect_irq_en_n}), 32'h1);
    @(posedge clk);
  endtask

  // Cuts a hung run short
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  // Reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_pen();
    t_channels();
    t_mode8_hold();
    t_abort();
    t_cs_ignore();
    tally_and_finish();
  end
endmodule
